// [rtl/usb_port_status_and_fifo_cpu_port.sv]
/*
 * ahb-lite register bank for two usb ports: host status, transceiver trims,
 * role select with clock gating enables, and a cpu window into per-port
 * read and write byte fifos whose far ends stream to endpoint logic.
 * assumes a single ahb master, word transfers, and pins from outside the
 * clk_i domain; transceiver select and join levels come from same-clock logic.
 */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module usb_port_regs
#(
	parameter bit IS_PORT1 = 1'b0
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register access from the bus slave
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [8:0] offset_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	// pins and same-clock controls
	input wire logic overcurrent_flag_pin_i,
	input wire logic line_dp_i,
	input wire logic line_dm_i,
	input wire logic bus_activity_i,
	input wire logic [1:0] transceiver_speed_select_i,
	input wire logic cpu_read_join_i,
	input wire logic cpu_write_join_i,
	// trims and clock enables
	output logic [1:0] tx_slew_level_o,
	output logic [1:0] tx_termination_level_o,
	output logic role_is_host_o,
	output logic host_clk_en_o,
	output logic device_clk_en_o,
	// endpoint side of the read fifo
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// endpoint side of the write fifo
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i
);
	localparam int AW = usb_port_regs_pkg::FIFO_AW;
	localparam logic [AW:0] DEPTH = (AW + 1)'(usb_port_regs_pkg::FIFO_DEPTH);

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
		logic [7:0] host_status;
		logic [1:0] slew;
		logic [1:0] term;
		logic role;
		logic host_clk_en;
		logic device_clk_en;
		logic [usb_port_regs_pkg::FIFO_DEPTH-1:0][7:0] rmem;
		logic [AW-1:0] rrd;
		logic [AW-1:0] rwr;
		logic [AW:0] rcnt;
		logic rx_ready;
		logic [usb_port_regs_pkg::FIFO_DEPTH-1:0][7:0] wmem;
		logic [AW-1:0] wrd;
		logic [AW-1:0] wwr;
		logic [AW:0] wcnt;
		logic tx_valid;
		logic [7:0] tx_data;
	} port_state_type;

	port_state_type s_r;
	port_state_type s_nxt;
	logic [7:0] head0;
	logic [7:0] head1;
	logic [1:0] line_code;

	assign head0 = s_r.rmem[s_r.rrd];
	assign head1 = s_r.rmem[AW'(s_r.rrd + 1'b1)];

	// line code from synced pins; low speed j/k sit on the opposite lines
	always_comb
	begin
		if (transceiver_speed_select_i == usb_port_regs_pkg::SEL_HIGH_SPEED)
		begin
			line_code = {1'b0, s_r.sync[2]};
		end
		else if (transceiver_speed_select_i == usb_port_regs_pkg::SEL_LOW_SPEED)
		begin
			line_code = {s_r.sync[0], s_r.sync[1]};
		end
		else
		begin
			line_code = {s_r.sync[1], s_r.sync[0]}; // code 10 unguaranteed
		end
	end

	// register read mux, no side effects here; pops happen in the state update
	always_comb
	begin
		rdata_o = 16'h0000;
		unique case (offset_i)
			usb_port_regs_pkg::IDX_HOST_BUS_STATUS: rdata_o = {8'h00, s_r.host_status};
			usb_port_regs_pkg::IDX_TRIM_CONFIG:
				rdata_o = {10'h000, s_r.slew, 2'h0, s_r.term};
			usb_port_regs_pkg::IDX_ROLE_SELECT: rdata_o = {15'h0000, s_r.role};
			usb_port_regs_pkg::IDX_FIFO_READ_LO:
			begin
				if (cpu_read_join_i && s_r.rcnt != '0)
				begin
					// only the low lane is valid when one byte remains
					rdata_o = {(s_r.rcnt > (AW + 1)'(1)) ? head1 : 8'h00, head0};
				end
			end
			usb_port_regs_pkg::IDX_READABLE_COUNT:
			begin
				rdata_o[usb_port_regs_pkg::COUNT_VALID_BIT] = cpu_read_join_i;
				if (cpu_read_join_i)
				begin
					rdata_o[usb_port_regs_pkg::COUNT_WIDTH-1:0] = 13'(s_r.rcnt);
				end
			end
			usb_port_regs_pkg::IDX_FREE_SPACE:
			begin
				if (cpu_write_join_i)
				begin
					rdata_o[usb_port_regs_pkg::COUNT_WIDTH-1:0] =
						13'(DEPTH - s_r.wcnt);
				end
			end
			usb_port_regs_pkg::IDX_BYTE_READ:
			begin
				if (cpu_read_join_i && s_r.rcnt != '0)
				begin
					rdata_o = {8'h00, head0};
				end
			end
			default: rdata_o = 16'h0000;
		endcase
	end

	// whole state update: pins, config, both fifos
	always_comb
	begin
		s_nxt = s_r;
		// two-flop synchronisers for flag, dp, dm and activity pins
		s_nxt.meta = {overcurrent_flag_pin_i, bus_activity_i, line_dm_i, line_dp_i};
		s_nxt.sync = s_r.meta;
		s_nxt.host_status = 8'h00;
		// status is refreshed every cycle, so it tracks pins even in sleep
		s_nxt.host_status[usb_port_regs_pkg::OVERCURRENT_BIT] = ~s_r.sync[3];
		s_nxt.host_status[1:0] = line_code;
		// configuration writes
		if (wr_en_i && offset_i == usb_port_regs_pkg::IDX_TRIM_CONFIG)
		begin
			s_nxt.slew = wdata_i[usb_port_regs_pkg::SLEW_LSB +: 2];
			s_nxt.term = wdata_i[usb_port_regs_pkg::TERM_LSB +: 2];
		end
		if (wr_en_i && offset_i == usb_port_regs_pkg::IDX_ROLE_SELECT)
		begin
			s_nxt.role = IS_PORT1 | wdata_i[usb_port_regs_pkg::ROLE_BIT];
		end
		if (IS_PORT1)
		begin
			s_nxt.role = 1'b1;
		end
		// common block always clocked; only one of host or device runs
		s_nxt.host_clk_en = s_nxt.role;
		s_nxt.device_clk_en = ~s_nxt.role;
		// read fifo: cpu pops first, then endpoint pushes
		if (rd_en_i && cpu_read_join_i && s_r.rcnt != '0)
		begin
			if (offset_i == usb_port_regs_pkg::IDX_FIFO_READ_LO)
			begin
				if (s_r.rcnt > (AW + 1)'(1))
				begin
					s_nxt.rrd = AW'(s_r.rrd + 2'd2);
					s_nxt.rcnt = (AW + 1)'(s_r.rcnt - 2'd2);
				end
				else
				begin
					s_nxt.rrd = AW'(s_r.rrd + 1'b1);
					s_nxt.rcnt = (AW + 1)'(s_r.rcnt - 1'b1);
				end
			end
			else if (offset_i == usb_port_regs_pkg::IDX_BYTE_READ)
			begin
				s_nxt.rrd = AW'(s_r.rrd + 1'b1);
				s_nxt.rcnt = (AW + 1)'(s_r.rcnt - 1'b1);
			end
		end
		// ready was taken from last cycle's count, so a push never overflows
		if (rx_valid_i && s_r.rx_ready)
		begin
			s_nxt.rmem[s_r.rwr] = rx_data_i;
			s_nxt.rwr = AW'(s_r.rwr + 1'b1);
			s_nxt.rcnt = (AW + 1)'(s_nxt.rcnt + 1'b1);
		end
		s_nxt.rx_ready = (s_nxt.rcnt < DEPTH) && !reset_i;
		// write fifo: endpoint pops first, then cpu pushes
		if (s_r.tx_valid && tx_ready_i)
		begin
			s_nxt.wrd = AW'(s_r.wrd + 1'b1);
			s_nxt.wcnt = (AW + 1)'(s_r.wcnt - 1'b1);
		end
		if (wr_en_i && cpu_write_join_i && s_r.wcnt != DEPTH)
		begin
			if (offset_i == usb_port_regs_pkg::IDX_FIFO_WRITE_LO)
			begin
				s_nxt.wmem[s_r.wwr] = wdata_i[7:0];
				if (s_r.wcnt < DEPTH - (AW + 1)'(1))
				begin
					// high lane stored only when two bytes are free
					s_nxt.wmem[AW'(s_r.wwr + 1'b1)] = wdata_i[15:8];
					s_nxt.wwr = AW'(s_r.wwr + 2'd2);
					s_nxt.wcnt = (AW + 1)'(s_nxt.wcnt + 2'd2);
				end
				else
				begin
					s_nxt.wwr = AW'(s_r.wwr + 1'b1);
					s_nxt.wcnt = (AW + 1)'(s_nxt.wcnt + 1'b1);
				end
			end
			else if (offset_i == usb_port_regs_pkg::IDX_BYTE_WRITE)
			begin
				s_nxt.wmem[s_r.wwr] = wdata_i[7:0];
				s_nxt.wwr = AW'(s_r.wwr + 1'b1);
				s_nxt.wcnt = (AW + 1)'(s_nxt.wcnt + 1'b1);
			end
		end
		// registered endpoint view of the write fifo head
		s_nxt.tx_valid = (s_nxt.wcnt != '0);
		s_nxt.tx_data = s_nxt.wmem[s_nxt.wrd];
		if (reset_i)
		begin
			s_nxt = '0;
			s_nxt.slew = usb_port_regs_pkg::SLEW_RESET;
			s_nxt.term = usb_port_regs_pkg::TERM_RESET;
			s_nxt.role = IS_PORT1 | usb_port_regs_pkg::ROLE_RESET;
			s_nxt.host_clk_en = IS_PORT1 | usb_port_regs_pkg::ROLE_RESET;
			s_nxt.device_clk_en = ~(IS_PORT1 | usb_port_regs_pkg::ROLE_RESET);
		end
	end

	always_ff @(posedge clk_i)
	begin
		s_r <= s_nxt;
	end

	assign tx_slew_level_o = s_r.slew;
	assign tx_termination_level_o = s_r.term;
	assign role_is_host_o = s_r.role;
	assign host_clk_en_o = s_r.host_clk_en;
	assign device_clk_en_o = s_r.device_clk_en;
	assign rx_ready_o = s_r.rx_ready;
	assign tx_valid_o = s_r.tx_valid;
	assign tx_data_o = s_r.tx_data;
endmodule : usb_port_regs

module usb_port_status_and_fifo_cpu_port
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// per-port pins, index is the usb port
	input wire logic [1:0] overcurrent_flag_pin_i,
	input wire logic [1:0] line_dp_i,
	input wire logic [1:0] line_dm_i,
	input wire logic [1:0] bus_activity_i,
	// per-port controls from same-clock logic
	input wire logic [1:0] transceiver_speed_select0_i,
	input wire logic [1:0] transceiver_speed_select1_i,
	input wire logic [1:0] cpu_read_join_i,
	input wire logic [1:0] cpu_write_join_i,
	// per-port trims and clock enables
	output logic [1:0] tx_slew_level0_o,
	output logic [1:0] tx_slew_level1_o,
	output logic [1:0] tx_termination_level0_o,
	output logic [1:0] tx_termination_level1_o,
	output logic [1:0] role_is_host_o,
	output logic [1:0] host_clk_en_o,
	output logic [1:0] device_clk_en_o,
	// endpoint streams into the read fifos
	input wire logic [1:0] rx_valid_i,
	input wire logic [7:0] rx_data0_i,
	input wire logic [7:0] rx_data1_i,
	output logic [1:0] rx_ready_o,
	// endpoint streams out of the write fifos
	output logic [1:0] tx_valid_o,
	output logic [7:0] tx_data0_o,
	output logic [7:0] tx_data1_o,
	input wire logic [1:0] tx_ready_i
);
	typedef struct packed {
		logic pend;
		logic write;
		logic mapped;
		logic port;
		logic [8:0] offset;
		logic readyout;
		logic [31:0] rdata;
	} bus_state_type;

	bus_state_type b_r;
	bus_state_type b_nxt;
	logic [1:0] acc_wr;
	logic [1:0] acc_rd;
	logic [15:0] rdata0;
	logic [15:0] rdata1;
	logic [9:0] idx;

	assign idx = haddr_i[usb_port_regs_pkg::IDX_MSB:usb_port_regs_pkg::IDX_LSB];

	// one wait state: the access runs in the first data-phase cycle
	always_comb
	begin
		b_nxt = b_r;
		acc_wr = 2'b00;
		acc_rd = 2'b00;
		if (b_r.pend)
		begin
			acc_wr[b_r.port] = b_r.write && b_r.mapped;
			acc_rd[b_r.port] = !b_r.write && b_r.mapped;
			b_nxt.rdata = 32'h0000_0000;
			if (!b_r.write && b_r.mapped)
			begin
				b_nxt.rdata[15:0] = b_r.port ? rdata1 : rdata0;
			end
			b_nxt.pend = 1'b0;
			b_nxt.readyout = 1'b1;
		end
		else if (hready_i && hsel_i && htrans_i[1])
		begin
			b_nxt.pend = 1'b1;
			b_nxt.readyout = 1'b0;
			b_nxt.write = hwrite_i;
			// port 1 mirrors port 0 at index 200h; anything above reads zero
			b_nxt.mapped = (haddr_i[31:usb_port_regs_pkg::IDX_MSB+1] == '0);
			b_nxt.port = idx[usb_port_regs_pkg::PORT_SEL_BIT];
			b_nxt.offset = idx[8:0];
		end
		if (reset_i)
		begin
			b_nxt = '0;
			b_nxt.readyout = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		b_r <= b_nxt;
	end

	// identical register group per usb port; port 1 is host only
	usb_port_regs #(.IS_PORT1(1'b0)) port0_regs (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_en_i(acc_wr[0]),
		.rd_en_i(acc_rd[0]),
		.offset_i(b_r.offset),
		.wdata_i(hwdata_i[15:0]),
		.rdata_o(rdata0),
		.overcurrent_flag_pin_i(overcurrent_flag_pin_i[0]),
		.line_dp_i(line_dp_i[0]),
		.line_dm_i(line_dm_i[0]),
		.bus_activity_i(bus_activity_i[0]),
		.transceiver_speed_select_i(transceiver_speed_select0_i),
		.cpu_read_join_i(cpu_read_join_i[0]),
		.cpu_write_join_i(cpu_write_join_i[0]),
		.tx_slew_level_o(tx_slew_level0_o),
		.tx_termination_level_o(tx_termination_level0_o),
		.role_is_host_o(role_is_host_o[0]),
		.host_clk_en_o(host_clk_en_o[0]),
		.device_clk_en_o(device_clk_en_o[0]),
		.rx_valid_i(rx_valid_i[0]),
		.rx_data_i(rx_data0_i),
		.rx_ready_o(rx_ready_o[0]),
		.tx_valid_o(tx_valid_o[0]),
		.tx_data_o(tx_data0_o),
		.tx_ready_i(tx_ready_i[0])
	);

	usb_port_regs #(.IS_PORT1(1'b1)) port1_regs (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_en_i(acc_wr[1]),
		.rd_en_i(acc_rd[1]),
		.offset_i(b_r.offset),
		.wdata_i(hwdata_i[15:0]),
		.rdata_o(rdata1),
		.overcurrent_flag_pin_i(overcurrent_flag_pin_i[1]),
		.line_dp_i(line_dp_i[1]),
		.line_dm_i(line_dm_i[1]),
		.bus_activity_i(bus_activity_i[1]),
		.transceiver_speed_select_i(transceiver_speed_select1_i),
		.cpu_read_join_i(cpu_read_join_i[1]),
		.cpu_write_join_i(cpu_write_join_i[1]),
		.tx_slew_level_o(tx_slew_level1_o),
		.tx_termination_level_o(tx_termination_level1_o),
		.role_is_host_o(role_is_host_o[1]),
		.host_clk_en_o(host_clk_en_o[1]),
		.device_clk_en_o(device_clk_en_o[1]),
		.rx_valid_i(rx_valid_i[1]),
		.rx_data_i(rx_data1_i),
		.rx_ready_o(rx_ready_o[1]),
		.tx_valid_o(tx_valid_o[1]),
		.tx_data_o(tx_data1_o),
		.tx_ready_i(tx_ready_i[1])
	);

	// responses are always okay, hsize is not checked (words only)
	assign hrdata_o = b_r.rdata;
	assign hreadyout_o = b_r.readyout;
	assign hresp_o = usb_port_regs_pkg::HRESP_OKAY;
endmodule : usb_port_status_and_fifo_cpu_port

`default_nettype wire

// [rtl/usb_port_regs_pkg.sv]
/*
 * constants for the per-port usb status, trim, role and fifo cpu window
 * register bank: register indices, field positions, reset values, depths.
 * assumes a 32-bit ahb-lite slave with one aligned word per register index.
 */
// Behaviour
// - host status bit 7 reads inverted overcurrent flag pin: 0 when high, 1 when low
// - host status stays readable with live pin values during sleep
// - select 01 or 11: line code SE0 00, J 01, K 10, SE1 11
// - select 00: line code shows bus activity, 01 present, 00 none
// - slew field bits 5:4 picks four slew rates, 00 slowest, 11 fastest
// - termination field bits 1:0 picks four levels, 00 highest, 11 lowest
// - role bit 0: 0 device, 1 host on port 0; port 1 reads 1
// - device role clocks device logic and stops host logic clock
// - host role clocks host logic and stops device logic clock
// - role select register stays accessible during sleep
// - two-byte read port pops joined read fifo; one byte left uses low lane only
// - two-byte write port pushes joined write fifo; one free byte stores low lane only
// - readable count bit 15 set only while a read fifo is joined and valid
// - readable count is 13 bits over high and low bytes, read as pair
// - free space register gives 13-bit unused capacity of joined write fifo
// - single byte read port pops one byte from joined read fifo
// - single byte write port pushes one byte into joined write fifo
// - port 0 registers at base 000h, port 1 at same offsets above 200h
package usb_port_regs_pkg;
	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_HOST_BUS_STATUS = 9'h019;
	localparam logic [8:0] IDX_TRIM_CONFIG = 9'h01b;
	localparam logic [8:0] IDX_ROLE_SELECT = 9'h01f;
	localparam logic [8:0] IDX_FIFO_READ_LO = 9'h020;
	localparam logic [8:0] IDX_FIFO_READ_HI = 9'h021;
	localparam logic [8:0] IDX_FIFO_WRITE_LO = 9'h022;
	localparam logic [8:0] IDX_FIFO_WRITE_HI = 9'h023;
	localparam logic [8:0] IDX_READABLE_COUNT = 9'h024;
	localparam logic [8:0] IDX_FREE_SPACE = 9'h026;
	localparam logic [8:0] IDX_BYTE_READ = 9'h028;
	localparam logic [8:0] IDX_BYTE_WRITE = 9'h02a;
	// port 1 base index and index field layout within haddr
	localparam logic [9:0] PORT1_BASE_IDX = 10'h200;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 11;
	localparam int PORT_SEL_BIT = 9;
	// field positions
	localparam int OVERCURRENT_BIT = 7;
	localparam int SLEW_LSB = 4;
	localparam int TERM_LSB = 0;
	localparam int ROLE_BIT = 0;
	localparam int COUNT_VALID_BIT = 15;
	localparam int COUNT_WIDTH = 13;
	// transceiver select codes
	localparam logic [1:0] SEL_HIGH_SPEED = 2'h0;
	localparam logic [1:0] SEL_LOW_SPEED = 2'h3;
	// reset values
	localparam logic [1:0] SLEW_RESET = 2'h0;
	localparam logic [1:0] TERM_RESET = 2'h0;
	localparam logic ROLE_RESET = 1'b0;
	// per-direction fifo depth in bytes (power of two)
	localparam int FIFO_AW = 5;
	localparam int FIFO_DEPTH = 32;
	// ahb codes
	localparam logic HRESP_OKAY = 1'b0;
endpackage : usb_port_regs_pkg

// [bench/usb_port_regs_checker.sv]
/*
 * concurrent checks on the usb port register bank: bus wait state, role and
 * clock enables, trim update cause, endpoint pop hold.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module usb_port_regs_checker
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// trims, role, stream
	input wire logic [1:0] tx_slew_level0_o,
	input wire logic [1:0] role_is_host_o,
	input wire logic [1:0] host_clk_en_o,
	input wire logic [1:0] device_clk_en_o,
	input wire logic [1:0] tx_valid_o,
	input wire logic [7:0] tx_data0_o,
	input wire logic [1:0] tx_ready_i
);
	// one domain, so one clocking and one disable
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// address phase accepted by the slave
	sequence take_s;
		hsel_i && hready_i && htrans_i[1];
	endsequence
	// write to the port 0 role select word
	sequence role_wr_s;
		take_s ##0 (hwrite_i && haddr_i == 32'h0000_007C);
	endsequence

	chk_wait_state: assert property (take_s |=> !hreadyout_o ##1 hreadyout_o)
		else $error("bus answer not after one wait state");
	chk_role_write: assert property (role_wr_s ##1 1'b1 |=> role_is_host_o[0] == $past(hwdata_i[0]))
		else $error("role bit did not take written value");
	chk_port1_host: assert property (role_is_host_o[1] == 1'b1)
		else $error("port 1 role not host");
	chk_clk_host: assert property (host_clk_en_o == role_is_host_o)
		else $error("host clock enable differs from role");
	chk_clk_device: assert property (device_clk_en_o == ~role_is_host_o)
		else $error("device clock enable differs from role");
	// port 0 slew trim moves only because of a write two edges earlier
	chk_slew_cause: assert property ($changed(tx_slew_level0_o) |->
		$past(hsel_i && hready_i && htrans_i[1] && hwrite_i, 2))
		else $error("slew level changed without a write");
	chk_tx_hold: assert property (tx_valid_o[0] && !tx_ready_i[0] |=> tx_valid_o[0] && $stable(tx_data0_o))
		else $error("stalled endpoint byte not held");
	chk_resp_okay: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
endmodule : usb_port_regs_checker

bind usb_port_status_and_fifo_cpu_port usb_port_regs_checker chk_u (.clk_i, .reset_i, .hsel_i,
	.haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
	.tx_slew_level0_o, .role_is_host_o, .host_clk_en_o, .device_clk_en_o, .tx_valid_o,
	.tx_data0_o, .tx_ready_i);

`default_nettype wire

// [bench/ep_model.sv]
/*
 * endpoint logic model for port 0: pushes bytes into the read fifo and
 * drains the write fifo, logging first and last byte and the pop count.
 * assumes tasks are called just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ep_model
(
	// clock and stall control
	input wire logic clk_i,
	input wire logic stall_i,
	// read fifo push side
	input wire logic rx_ready_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	// write fifo pop side
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	int pops;
	logic [7:0] first_byte;
	logic [7:0] last_byte;

	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b0;
		pops = 0;
	end

	// pop log; ready follows stall one edge late, like a slow consumer
	always @(posedge clk_i)
	begin
		if (tx_valid_i && tx_ready_o)
		begin
			if (pops == 0)
				first_byte = tx_data_i;
			last_byte = tx_data_i;
			pops++;
		end
		tx_ready_o <= !stall_i;
	end

	// byte held until taken; idle data inverted so stale bytes never match
	task push(input logic [7:0] b);
		rx_valid_o <= 1'b1;
		rx_data_o <= b;
		do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~b;
		@(posedge clk_i);
	endtask : push
endmodule : ep_model

`default_nettype wire

// [bench/usb_port_status_and_fifo_cpu_port_bench.sv]
/*
 * self-checking bench for the usb port register bank over ahb-lite:
 * status and line codes, trims, role, fifo cpu window, port mirror.
 * assumes ep_model on port 0 streams and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module usb_port_status_and_fifo_cpu_port_bench;
	logic clk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, stall = 1'b1;
	logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o;
	logic [1:0] htrans_i = 2'b00, overcurrent_flag_pin_i = 2'b11, line_dp_i = 2'b00;
	logic [1:0] line_dm_i = 2'b00, bus_activity_i = 2'b00, cpu_read_join_i = 2'b00;
	logic [1:0] transceiver_speed_select0_i = 2'b01, cpu_write_join_i = 2'b00;
	logic [1:0] tx_slew_level0_o, tx_slew_level1_o, tx_termination_level0_o, rx_ready_o;
	logic [1:0] role_is_host_o, host_clk_en_o, device_clk_en_o, tx_valid_o;
	logic [1:0] tx_termination_level1_o;
	logic [7:0] rx_data0_i, tx_data0_o;
	logic hreadyout_o, hresp_o, m_rxv, m_txr;
	wire logic [1:0] rx_valid_i = {1'b0, m_rxv};
	wire logic [1:0] tx_ready_i = {1'b0, m_txr};
	int errors = 0, check_count = 0;
	logic [31:0] i;

	// clock, 10 ns period
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	usb_port_status_and_fifo_cpu_port dut_u (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .overcurrent_flag_pin_i, .line_dp_i, .line_dm_i, .bus_activity_i,
		.transceiver_speed_select0_i, .transceiver_speed_select1_i(2'b01), .cpu_read_join_i,
		.cpu_write_join_i, .tx_slew_level0_o, .tx_slew_level1_o, .tx_termination_level0_o,
		.tx_termination_level1_o, .role_is_host_o, .host_clk_en_o, .device_clk_en_o,
		.rx_valid_i, .rx_data0_i, .rx_data1_i(8'h00), .rx_ready_o, .tx_valid_o, .tx_data0_o,
		.tx_data1_o(), .tx_ready_i);

	ep_model ep_u (.clk_i, .stall_i(stall), .rx_ready_i(rx_ready_o[0]), .rx_valid_o(m_rxv),
		.rx_data_o(rx_data0_i), .tx_valid_i(tx_valid_o[0]), .tx_data_i(tx_data0_o),
		.tx_ready_o(m_txr));

	function automatic logic [31:0] ad(input logic p, input logic [8:0] idx);
		return {20'h0_0000, p, idx, 2'b00};
	endfunction : ad

	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, s, e);
		end
	endtask : chk

	// one single transfer; holds each phase until ready seen at an edge, no cycle limit
	// of its own so that only the watchdog ends a hung slave
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask : bus

	task rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(r, e);
	endtask : rd

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task settle();
		repeat (6) @(posedge clk_i);
	endtask : settle

	task summarize();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// hang guard, well beyond the few hundred cycles the tests need
	initial
	begin
		#200us;
		errors++;
		summarize();
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rd(ad(0, usb_port_regs_pkg::IDX_ROLE_SELECT), 32'h0000_0000);
		rd(ad(1, usb_port_regs_pkg::IDX_ROLE_SELECT), 32'h0000_0001);
		rd(ad(0, usb_port_regs_pkg::IDX_READABLE_COUNT), 32'h0000_0000);
		rd(ad(0, 9'h030), 32'h0000_0000);
		$display("test reset done");
		// full speed then low speed line codes; select 10 never used
		overcurrent_flag_pin_i <= 2'b10;
		for (i = 0; i < 4; i++)
		begin
			{line_dm_i[0], line_dp_i[0]} <= i[1:0];
			settle();
			rd(ad(0, usb_port_regs_pkg::IDX_HOST_BUS_STATUS), 32'h0000_0080 | i);
		end
		transceiver_speed_select0_i <= 2'b11;
		// low speed j and k sit on the opposite lines
		for (i = 0; i < 4; i++)
		begin
			{line_dm_i[0], line_dp_i[0]} <= i[1:0];
			settle();
			rd(ad(0, usb_port_regs_pkg::IDX_HOST_BUS_STATUS),
				32'h0000_0080 | {30'h0, i[0], i[1]});
		end
		transceiver_speed_select0_i <= 2'b00;
		for (i = 0; i < 2; i++)
		begin
			bus_activity_i[0] <= i[0];
			settle();
			rd(ad(0, usb_port_regs_pkg::IDX_HOST_BUS_STATUS), 32'h0000_0080 | i);
		end
		overcurrent_flag_pin_i <= 2'b11;
		settle();
		rd(ad(0, usb_port_regs_pkg::IDX_HOST_BUS_STATUS), 32'h0000_0001);
		$display("test status done");
		// every slew and termination code, opposite orders
		for (i = 0; i < 4; i++)
		begin
			wr(ad(0, usb_port_regs_pkg::IDX_TRIM_CONFIG), {26'h0, i[1:0], 2'b00, ~i[1:0]});
			chk({30'h0, tx_slew_level0_o}, i);
			chk({30'h0, tx_termination_level0_o}, 32'h0000_0003 - i);
			rd(ad(0, usb_port_regs_pkg::IDX_TRIM_CONFIG), {26'h0, i[1:0], 2'b00, ~i[1:0]});
		end
		wr(ad(1, usb_port_regs_pkg::IDX_TRIM_CONFIG), 32'h0000_0012);
		chk({30'h0, tx_slew_level1_o}, 32'h0000_0001);
		chk({30'h0, tx_termination_level1_o}, 32'h0000_0002);
		chk({30'h0, tx_slew_level0_o}, 32'h0000_0003);
		$display("test trim done");
		wr(ad(0, usb_port_regs_pkg::IDX_ROLE_SELECT), 32'h0000_0001);
		chk({28'h0, host_clk_en_o, device_clk_en_o}, 32'h0000_000C);
		wr(ad(0, usb_port_regs_pkg::IDX_ROLE_SELECT), 32'h0000_0000);
		chk({28'h0, host_clk_en_o, device_clk_en_o}, 32'h0000_0009);
		$display("test role done");
		// read window: word pop, odd byte left, single byte pop
		cpu_read_join_i <= 2'b01;
		for (i = 0; i < 3; i++)
			ep_u.push(8'hA0 + i[7:0]);
		rd(ad(0, usb_port_regs_pkg::IDX_READABLE_COUNT), 32'h0000_8003);
		rd(ad(0, usb_port_regs_pkg::IDX_FIFO_READ_LO), 32'h0000_A1A0);
		rd(ad(0, usb_port_regs_pkg::IDX_READABLE_COUNT), 32'h0000_8001);
		rd(ad(0, usb_port_regs_pkg::IDX_FIFO_READ_LO), 32'h0000_00A2);
		rd(ad(0, usb_port_regs_pkg::IDX_READABLE_COUNT), 32'h0000_8000);
		ep_u.push(8'hA3);
		rd(ad(0, usb_port_regs_pkg::IDX_BYTE_READ), 32'h0000_00A3);
		cpu_read_join_i <= 2'b00;
		rd(ad(0, usb_port_regs_pkg::IDX_READABLE_COUNT), 32'h0000_0000);
		$display("test read fifo done");
		// write window filled to an odd last byte while the endpoint stalls
		cpu_write_join_i <= 2'b01;
		rd(ad(0, usb_port_regs_pkg::IDX_FREE_SPACE), 32'h0000_0020);
		wr(ad(0, usb_port_regs_pkg::IDX_FIFO_WRITE_LO), 32'h0000_5B5A);
		rd(ad(0, usb_port_regs_pkg::IDX_FREE_SPACE), 32'h0000_001E);
		wr(ad(0, usb_port_regs_pkg::IDX_BYTE_WRITE), 32'h0000_0077);
		rd(ad(0, usb_port_regs_pkg::IDX_FREE_SPACE), 32'h0000_001D);
		for (i = 0; i < 14; i++)
			wr(ad(0, usb_port_regs_pkg::IDX_FIFO_WRITE_LO), 32'h0000_1212);
		rd(ad(0, usb_port_regs_pkg::IDX_FREE_SPACE), 32'h0000_0001);
		wr(ad(0, usb_port_regs_pkg::IDX_FIFO_WRITE_LO), 32'h0000_CCDD);
		rd(ad(0, usb_port_regs_pkg::IDX_FREE_SPACE), 32'h0000_0000);
		wr(ad(0, usb_port_regs_pkg::IDX_BYTE_WRITE), 32'h0000_0099);
		stall <= 1'b0;
		for (i = 0; i < 200 && ep_u.pops < 32; i++)
			@(posedge clk_i);
		repeat (4) @(posedge clk_i);
		chk(ep_u.pops, 32'h0000_0020);
		chk({24'h0, ep_u.first_byte}, 32'h0000_005A);
		chk({24'h0, ep_u.last_byte}, 32'h0000_00DD);
		$display("test write fifo done");
		summarize();
	end
endmodule : usb_port_status_and_fifo_cpu_port_bench

`default_nettype wire
